// file: common/dffg_defs.vh
// constants for the dual gated-clock d storage block
// Summary of operation
// RQ1 - effective clock is enable pin OR common clock
// RQ2 - independent clocking: common low, pulse enables
// RQ3 - common clocking needs enables held low
// RQ4 - rising effective clock loads data into output
// RQ5 - otherwise output holds, data changes ignored
// RQ6 - set and reset override clock and data
// RQ7 - set drives high, reset drives low, both high hold
// RQ8 - complement output always inverse of true output
`ifndef DFFG_DEFS_VH
`define DFFG_DEFS_VH
`define DFFG_NUM_ELEM  2
`define DFFG_RST_Q     1'b0
`define DFFG_RST_QN    1'b1
`define DFFG_RST_PIN   1'b0
`endif

// file: src/dffg_dual_top.v
// dual d storage element with shared clock and per-element enable gates
`timescale 1ns/1ns
`include "dffg_defs.vh"
module dffg_dual_top (
	// clock and reset
	input  wire                        clk,
	input  wire                        arst_n,
	// shared clock pin
	input  wire                        commonClk,
	// per-element pins
	input  wire [`DFFG_NUM_ELEM-1:0]   enableN,
	input  wire [`DFFG_NUM_ELEM-1:0]   dataIn,
	input  wire [`DFFG_NUM_ELEM-1:0]   setIn,
	input  wire [`DFFG_NUM_ELEM-1:0]   resetIn,
	// stored outputs
	output reg  [`DFFG_NUM_ELEM-1:0]   q_r,
	output reg  [`DFFG_NUM_ELEM-1:0]   qN_r
);
	localparam NE = `DFFG_NUM_ELEM;

	// force codes from the set and reset pair
	localparam [1:0] FORCE_NONE = 2'h0;
	localparam [1:0] FORCE_SET  = 2'h1;
	localparam [1:0] FORCE_CLR  = 2'h2;
	localparam [1:0] FORCE_BOTH = 2'h3;

	// filtered pin levels
	wire            clkF;
	wire [NE-1:0]   enF;
	wire [NE-1:0]   dF;
	wire [NE-1:0]   sF;
	wire [NE-1:0]   rF;

	// effective clock and its history
	wire [NE-1:0]   effClk;
	wire [NE-1:0]   effRise;
	reg  [NE-1:0]   effPrev_r;

	// force codes and next stored values
	wire [2*NE-1:0] forceCode;
	reg  [NE-1:0]   q_nxt;
	reg  [NE-1:0]   qN_nxt;
	genvar          g;

	// effective clock from enable level and common clock
	function gate_of;
		input enLvl;
		input clkLvl;
		begin
			gate_of = enLvl | clkLvl;
		end
	endfunction

	// decode set and reset levels into a force code
	function [1:0] force_of;
		input setLvl;
		input rstLvl;
		begin
			if (setLvl && !rstLvl) begin
				force_of = FORCE_SET;
			end else if (rstLvl && !setLvl) begin
				force_of = FORCE_CLR;
			end else if (setLvl && rstLvl) begin
				force_of = FORCE_BOTH;
			end else begin
				force_of = FORCE_NONE;
			end
		end
	endfunction

	// rising edge of a level against its history
	function rise_of;
		input nowLvl;
		input prevLvl;
		begin
			if (nowLvl && !prevLvl) begin
				rise_of = 1'b1;
			end else begin
				rise_of = 1'b0;
			end
		end
	endfunction

	// next stored bit from force code, edge and data
	function next_of;
		input       curBit;
		input [1:0] code;
		input       rise;
		input       datBit;
		begin
			case (code)
				FORCE_SET: begin
					next_of = 1'b1; // RQ6 RQ7
				end
				FORCE_CLR: begin
					next_of = 1'b0; // RQ6 RQ7
				end
				FORCE_BOTH: begin
					next_of = curBit; // RQ7
				end
				default: begin
					if (rise) begin
						next_of = datBit; // RQ4
					end else begin
						next_of = curBit; // RQ5
					end
				end
			endcase
		end
	endfunction

	// shared clock pin from the board
	dffg_pin_sync #(
		.WIDTH(1)
	) uSyncClk (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (commonClk),
		.pinFilt_r(clkF)
	);

	// enable pins from the board
	dffg_pin_sync #(
		.WIDTH(NE)
	) uSyncEn (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (enableN),
		.pinFilt_r(enF)
	);

	// data pins from the board
	dffg_pin_sync #(
		.WIDTH(NE)
	) uSyncData (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (dataIn),
		.pinFilt_r(dF)
	);

	// set pins from the board
	dffg_pin_sync #(
		.WIDTH(NE)
	) uSyncSet (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (setIn),
		.pinFilt_r(sF)
	);

	// reset pins from the board
	dffg_pin_sync #(
		.WIDTH(NE)
	) uSyncRst (
		.clk      (clk),
		.arst_n   (arst_n),
		.pinIn    (resetIn),
		.pinFilt_r(rF)
	);

	// gated clock and edge history per element
	generate
		for (g = 0; g < NE; g = g + 1) begin : gEdge
			assign effClk[g]  = gate_of(enF[g], clkF); // RQ1
			assign effRise[g] = rise_of(effClk[g], effPrev_r[g]); // RQ4

			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					effPrev_r[g] <= `DFFG_RST_PIN;
				end else begin
					effPrev_r[g] <= effClk[g];
				end
			end
		end
	endgenerate

	// set and reset priority per element
	generate
		for (g = 0; g < NE; g = g + 1) begin : gForce
			assign forceCode[2*g+1:2*g] = force_of(sF[g], rF[g]); // RQ6
		end
	endgenerate

	// next stored value per element
	generate
		for (g = 0; g < NE; g = g + 1) begin : gNext
			always @* begin
				q_nxt[g] = next_of(q_r[g], forceCode[2*g+1:2*g], effRise[g], dF[g]);
			end

			always @* begin
				qN_nxt[g] = ~q_nxt[g]; // RQ8
			end
		end
	endgenerate

	// true outputs per element
	generate
		for (g = 0; g < NE; g = g + 1) begin : gOutQ
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					q_r[g] <= `DFFG_RST_Q;
				end else begin
					q_r[g] <= q_nxt[g];
				end
			end
		end
	endgenerate

	// complement outputs per element
	generate
		for (g = 0; g < NE; g = g + 1) begin : gOutQn
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					qN_r[g] <= `DFFG_RST_QN;
				end else begin
					qN_r[g] <= qN_nxt[g]; // RQ8
				end
			end
		end
	endgenerate
endmodule

// file: src/dffg_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "dffg_defs.vh"
module dffg_pin_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             arst_n,
	// pin side
	input  wire [WIDTH-1:0] pinIn,
	// filtered level
	output reg  [WIDTH-1:0] pinFilt_r
);
	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;
	reg [WIDTH-1:0] stage3_r;
	genvar i;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_r <= {WIDTH{`DFFG_RST_PIN}};
			stage2_r <= {WIDTH{`DFFG_RST_PIN}};
			stage3_r <= {WIDTH{`DFFG_RST_PIN}};
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// a bit changes only once stages two and three agree
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gFilt
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					pinFilt_r[i] <= `DFFG_RST_PIN;
				end else if (stage2_r[i] == stage3_r[i]) begin
					pinFilt_r[i] <= stage3_r[i];
				end
			end
		end
	endgenerate
endmodule

// file: tb/dffg_chk_properties.sv
// concurrent checks on the dual gated-clock storage block
`timescale 1ns/1ns
module dffg_chk (
	// clock and reset
	input wire       clk,
	input wire       arst_n,
	// board pins
	input wire       commonClk,
	input wire [1:0] enableN,
	input wire [1:0] dataIn,
	input wire [1:0] setIn,
	input wire [1:0] resetIn,
	// stored outputs
	input wire [1:0] q_r,
	input wire [1:0] qN_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence sSetHeld;
		(setIn[0] && !resetIn[0])[*6];
	endsequence

	sequence sClrHeld;
		(resetIn[1] && !setIn[1])[*6];
	endsequence

	sequence sBothHeld;
		(setIn[1] && resetIn[1])[*6];
	endsequence

	sequence sEffLow;
		(!(enableN[0] || commonClk) && !setIn[0] && !resetIn[0])[*4];
	endsequence

	sequence sEffRise;
		((enableN[0] || commonClk) && !setIn[0] && !resetIn[0] && $stable(dataIn[0]))[*6];
	endsequence

	sequence sEffHigh;
		((enableN[0] || commonClk) && !setIn[0] && !resetIn[0])[*8];
	endsequence

	a_compl_out: assert property (qN_r == ~q_r)
		else $error("complement output differs from true output");
	a_set_high: assert property (sSetHeld |=> q_r[0])
		else $error("held set did not force output high");
	a_reset_low: assert property (sClrHeld |=> !q_r[1])
		else $error("held reset did not force output low");
	a_both_hold: assert property (sBothHeld |=> $stable(q_r[1]))
		else $error("set and reset together changed the output");
	a_clk_load: assert property (sEffLow ##1 sEffRise |=> q_r[0] == $past(dataIn[0]))
		else $error("effective clock rise did not load data");
	a_data_hold: assert property (sEffHigh |=> $stable(q_r[0]))
		else $error("output changed while effective clock stayed high");
endmodule
bind dffg_dual_top dffg_chk CHK(.clk, .arst_n, .commonClk, .enableN, .dataIn, .setIn, .resetIn, .q_r, .qN_r);

// file: tb/dffg_dual_top_bench.sv
// bench for the dual gated-clock storage block
`timescale 1ns/1ns
module dffg_dual_top_bench;
	reg        clk = 1'h0;
	reg        rn = 1'h0;
	reg        p = 1'h0;
	reg  [1:0] s = 2'h0;
	reg  [1:0] d = 2'h0;
	reg  [1:0] st = 2'h0;
	reg  [1:0] rs = 2'h0;
	reg  [1:0] x = 2'h0;
	reg  [1:0] dv = 2'h0;
	reg  [7:0] r = 8'h5F;
	wire       c;
	wire [1:0] e;
	wire [1:0] q;
	wire [1:0] qn;
	integer    n_errors = 0;
	integer    compares = 0;
	integer    t;
	always #5 clk = ~clk;
	dffg_src SRC(.p(p), .s(s), .c(c), .e(e));
	dffg_dual_top DUT(.clk(clk), .arst_n(rn), .commonClk(c), .enableN(e), .dataIn(d), .setIn(st),
		.resetIn(rs), .q_r(q), .qN_r(qn));
	function [7:0] lf(input [7:0] v);
		lf = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// expected outputs after one clock pulse from the rules
	function [1:0] exp_q(input [1:0] prev, input [1:0] so, input [1:0] ro, input [1:0] dd, input [1:0] sel);
		integer j;
		begin
			exp_q = prev;
			for (j = 0; j < 2; j = j + 1) begin
				if (so[j] ^ ro[j])
					exp_q[j] = so[j];
				else if (!ro[j] && (sel == 2'h0 || sel[j]))
					exp_q[j] = dd[j];
			end
		end
	endfunction
	task chk(input [15:0] n, input [1:0] seen, want);
		compares=compares+1;
		if (seen!==want) begin
			n_errors=n_errors+1;
			$display("CHECK FAILED %s exp %h seen %h", n, want, seen);
		end
	endtask
	task close_out;
		if (n_errors==0 && compares>0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rn <= 1'h1;
		@(negedge clk);
		chk("qN", qn, 2'h3);
		for (t = 0; t < 64; t = t + 1) begin
			@(posedge clk);
			// mid-run reset corner case
			if (t == 32) begin
				rn <= 1'h0;
				@(negedge clk);
				chk("qR", q, 2'h0);
				chk("qN", qn, 2'h3);
				repeat (4) @(posedge clk);
				rn <= 1'h1;
				x = 2'h0;
			end
			r = lf(r);
			{st, rs, d} <= {r[4:3] & {2{r[7]}}, r[6:5] & {2{r[7]}}, r[1:0]};
			s <= t[1:0];
			repeat (8) @(posedge clk);
			p <= 1'h1;
			repeat (8) @(posedge clk);
			dv = d;
			d <= ~d;
			repeat (8) @(posedge clk);
			p <= 1'h0;
			repeat (8) @(posedge clk);
			@(negedge clk);
			x = exp_q(x, st, rs, dv, s);
			chk("q", q, x);
			chk("qN", qn, ~x);
		end
		close_out;
	end
endmodule

// file: tb/dffg_src.sv
// board clock source
`timescale 1ns/1ns
module dffg_src (
	// board pulse and element select
	input  wire       p,
	input  wire [1:0] s,
	// gated clock pins
	output wire       c,
	output wire [1:0] e
);
	assign c = p & ~|s;
	assign e = s & {2{p}};
endmodule
